// ### event_sources.sv
// model of the peripheral event sources feeding one-cycle request pulses
`timescale 1ns/100ps
`default_nettype none
module event_sources (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] fire,
    output logic [15:0] events
);
    // registered so a request made with an apb setup lands in its access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 16'h0000;
        end else begin
            events <= fire;
        end
    end
endmodule : event_sources
`default_nettype wire

// ### irq_flags_pkg.sv
// package: register map, field positions and reset values of the peripheral request flags
package irq_flags_pkg;
    localparam logic [11:0] off_request_0 = 12'h000;
    localparam logic [11:0] off_request_1 = 12'h004;
    localparam logic [11:0] off_request_2 = 12'h008;
    localparam logic [11:0] off_change_flags = 12'h00c;
    localparam logic [11:0] off_rising_mask = 12'h010;
    localparam logic [11:0] off_falling_mask = 12'h014;
    // request 0 fields
    localparam int pos_timer_zero = 5;
    localparam int pos_pin_change = 4;
    localparam int pos_ext_pin = 0;
    localparam logic [7:0] request_0_used = 8'h31;
    localparam logic [7:0] request_0_writable = 8'h21;
    // request 1 fields
    localparam int pos_timer_one_gate = 7;
    localparam int pos_conversion = 6;
    localparam int pos_serial_rx = 5;
    localparam int pos_serial_tx = 4;
    localparam int pos_port_one = 3;
    localparam int pos_port_one_coll = 2;
    localparam int pos_timer_two = 1;
    localparam int pos_timer_one_ovf = 0;
    localparam logic [7:0] request_1_writable = 8'hcf;
    // request 2: all eight bits hardware set, software cleared
    localparam logic [7:0] request_2_writable = 8'hff;
    localparam logic [7:0] flags_reset = 8'h00;
    localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage : irq_flags_pkg

// ### peripheral_irq_flags.sv
// top: three peripheral interrupt request registers with pin-change bank behind apb
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flags #(
    parameter int pins = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pins-1:0] pin_in,
    input wire logic ext_pin_in,
    input wire logic timer_zero_overflow,
    input wire logic timer_one_gate_close,
    input wire logic conversion_done,
    input wire logic rx_buffer_not_empty,
    input wire logic tx_buffer_empty,
    input wire logic port_one_done,
    input wire logic port_one_collision,
    input wire logic timer_two_match,
    input wire logic timer_one_overflow,
    input wire logic [7:0] request_2_events,
    output logic [7:0] irq_request_0,
    output logic [7:0] irq_request_1,
    output logic [7:0] irq_request_2
);
    if (pins < 1 || pins > 32) begin : g_bad_pins
        $error("peripheral_irq_flags: pins must be 1..32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] req0;
        logic [7:0] req1;
        logic [7:0] req2;
        logic [pins-1:0] rise_mask;
        logic [pins-1:0] fall_mask;
        logic ext_sync_a;
        logic ext_sync_b;
        logic ext_last;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [7:0] out0;
        logic [7:0] out1;
        logic [7:0] out2;
    } flags_state_t;

    flags_state_t state;
    flags_state_t next_state;
    logic [pins-1:0] change_flags;
    logic [pins-1:0] change_clear;
    logic summary;
    logic wr_access;
    logic rd_access;
    logic [7:0] clear0;
    logic [7:0] clear1;
    logic [7:0] clear2;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] view0;
    logic [7:0] view1;
    logic [31:0] wide_pwdata;
    logic mapped;

    pin_change_detect #(
        .pins(pins)
    ) u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin_in),
        .rising_edge_mask(state.rise_mask),
        .falling_edge_mask(state.fall_mask),
        .clear_bits(change_clear),
        .per_pin_change_flags(change_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // zero-wait slave: pready answers in the first access cycle
    assign wr_access = psel && penable && pwrite && state.ready;
    assign rd_access = psel && !penable && !pwrite;
    assign wide_pwdata = pwdata;

    always_comb begin
        mapped = (paddr == irq_flags_pkg::off_request_0) || (paddr == irq_flags_pkg::off_request_1)
            || (paddr == irq_flags_pkg::off_request_2) || (paddr == irq_flags_pkg::off_change_flags)
            || (paddr == irq_flags_pkg::off_rising_mask) || (paddr == irq_flags_pkg::off_falling_mask);
    end

    // software writes zero to clear a request flag, as on a plain bit write; ones leave it
    always_comb begin
        clear0 = '0;
        clear1 = '0;
        clear2 = '0;
        change_clear = '0;
        if (wr_access && pstrb[0]) begin
            // only writable positions take a clear
            if (paddr == irq_flags_pkg::off_request_0) begin
                clear0 = ~wide_pwdata[7:0] & irq_flags_pkg::request_0_writable;
            end
            if (paddr == irq_flags_pkg::off_request_1) begin
                clear1 = ~wide_pwdata[7:0] & irq_flags_pkg::request_1_writable;
            end
            if (paddr == irq_flags_pkg::off_request_2) begin
                clear2 = ~wide_pwdata[7:0] & irq_flags_pkg::request_2_writable;
            end
        end
        // per-pin flags clear on writing a one, so other pins are not disturbed
        if (wr_access && paddr == irq_flags_pkg::off_change_flags) begin
            change_clear = wide_pwdata[pins-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // hardware set terms

    // summary is a live or of the per-pin flags
    assign summary = |change_flags;

    always_comb begin
        set0 = '0;
        set1 = '0;
        set0[irq_flags_pkg::pos_timer_zero] = timer_zero_overflow;
        set0[irq_flags_pkg::pos_ext_pin] = state.ext_sync_b && !state.ext_last;
        set1[irq_flags_pkg::pos_timer_one_gate] = timer_one_gate_close;
        set1[irq_flags_pkg::pos_conversion] = conversion_done;
        set1[irq_flags_pkg::pos_port_one] = port_one_done;
        set1[irq_flags_pkg::pos_port_one_coll] = port_one_collision;
        set1[irq_flags_pkg::pos_timer_two] = timer_two_match;
        set1[irq_flags_pkg::pos_timer_one_ovf] = timer_one_overflow;
    end

    always_comb begin
        view0 = state.req0 & irq_flags_pkg::request_0_writable;
        // read only summary in its bit
        view0[irq_flags_pkg::pos_pin_change] = summary;
        view1 = state.req1 & irq_flags_pkg::request_1_writable;
        view1[irq_flags_pkg::pos_serial_rx] = rx_buffer_not_empty;
        view1[irq_flags_pkg::pos_serial_tx] = tx_buffer_empty;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_state = state;
        next_state.ext_sync_a = ext_pin_in;
        next_state.ext_sync_b = state.ext_sync_a;
        next_state.ext_last = state.ext_sync_b;
        // no enable gates the set terms
        // set wins over a same cycle clear
        next_state.req0 = ((state.req0 & ~clear0) | set0) & irq_flags_pkg::request_0_writable;
        next_state.req1 = ((state.req1 & ~clear1) | set1) & irq_flags_pkg::request_1_writable;
        next_state.req2 = (state.req2 & ~clear2) | request_2_events;
        if (wr_access && paddr == irq_flags_pkg::off_rising_mask) begin
            next_state.rise_mask = wide_pwdata[pins-1:0];
        end
        if (wr_access && paddr == irq_flags_pkg::off_falling_mask) begin
            next_state.fall_mask = wide_pwdata[pins-1:0];
        end
        next_state.ready = psel && !penable;
        next_state.err = psel && !penable && !mapped;
        next_state.rdata = irq_flags_pkg::read_zero;
        if (rd_access) begin
            unique case (paddr)
                irq_flags_pkg::off_request_0: next_state.rdata = {24'h00_0000, view0};
                irq_flags_pkg::off_request_1: next_state.rdata = {24'h00_0000, view1};
                irq_flags_pkg::off_request_2: next_state.rdata = {24'h00_0000, state.req2};
                irq_flags_pkg::off_change_flags: next_state.rdata = 32'(change_flags);
                irq_flags_pkg::off_rising_mask: next_state.rdata = 32'(state.rise_mask);
                irq_flags_pkg::off_falling_mask: next_state.rdata = 32'(state.fall_mask);
                default: next_state.rdata = irq_flags_pkg::read_zero;
            endcase
        end
        next_state.out0 = view0;
        next_state.out1 = view1;
        next_state.out2 = state.req2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = state.err;
    assign irq_request_0 = state.out0;
    assign irq_request_1 = state.out1;
    assign irq_request_2 = state.out2;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence write_clear_req0;
        wr_access && pstrb[0] && paddr == irq_flags_pkg::off_request_0
            && !pwdata[irq_flags_pkg::pos_timer_zero];
    endsequence

    // setup cycle of a transfer; the answer must follow in the very next cycle
    sequence apb_setup;
        psel && !penable;
    endsequence

    a_unused_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_request_0 & ~irq_flags_pkg::request_0_used) == 8'h00)
        else $error("unimplemented request 0 bit reads nonzero");
    a_timer_zero_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        timer_zero_overflow |=> state.req0[irq_flags_pkg::pos_timer_zero] ##1
        irq_request_0[irq_flags_pkg::pos_timer_zero])
        else $error("timer zero overflow flag not set");
    a_summary_is_or: assert property (@(posedge pclk) disable iff (!presetn)
        irq_request_0[irq_flags_pkg::pos_pin_change] == ($past(change_flags) != '0))
        else $error("summary flag differs from or of pin flags");
    a_ext_pin_sets: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state.ext_sync_b) |=> state.req0[irq_flags_pkg::pos_ext_pin])
        else $error("external pin flag not set on edge");
    a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (write_clear_req0 and timer_zero_overflow) |=> state.req0[irq_flags_pkg::pos_timer_zero])
        else $error("event lost under same cycle clear");
    a_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
        (write_clear_req0 and !timer_zero_overflow) |=> !state.req0[irq_flags_pkg::pos_timer_zero])
        else $error("software clear of timer zero flag failed");
    a_rx_follows: assert property (@(posedge pclk) disable iff (!presetn)
        irq_request_1[irq_flags_pkg::pos_serial_rx] == $past(rx_buffer_not_empty))
        else $error("receive flag does not follow buffer");
    a_tx_follows: assert property (@(posedge pclk) disable iff (!presetn)
        irq_request_1[irq_flags_pkg::pos_serial_tx] == $past(tx_buffer_empty))
        else $error("transmit flag does not follow buffer");
    a_conv_sets: assert property (@(posedge pclk) disable iff (!presetn)
        conversion_done |=> state.req1[irq_flags_pkg::pos_conversion])
        else $error("conversion flag not set");
    a_req2_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[7] |=> state.req2[7] ##1 irq_request_2[7])
        else $error("timer six match flag not set");
    a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        apb_setup |=> pready ##1 !pready)
        else $error("apb ready not a single access cycle");

    // sticky request 0 flags
    a_timer_zero_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state.req0[irq_flags_pkg::pos_timer_zero] && !(wr_access && paddr == irq_flags_pkg::off_request_0)
        |=> state.req0[irq_flags_pkg::pos_timer_zero])
        else $error("timer zero flag dropped without a clear");
    a_ext_pin_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state.req0[irq_flags_pkg::pos_ext_pin] && !(wr_access && paddr == irq_flags_pkg::off_request_0)
        |=> state.req0[irq_flags_pkg::pos_ext_pin])
        else $error("external pin flag dropped without a clear");

    // request 1 set terms
    a_gate_close_sets: assert property (@(posedge pclk) disable iff (!presetn)
        timer_one_gate_close |=> state.req1[irq_flags_pkg::pos_timer_one_gate])
        else $error("timer one gate flag not set");
    a_port_one_sets: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_done |=> state.req1[irq_flags_pkg::pos_port_one])
        else $error("sync port one flag not set");
    a_port_one_coll: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_collision |=> state.req1[irq_flags_pkg::pos_port_one_coll])
        else $error("sync port one collision flag not set");
    a_timer_two_sets: assert property (@(posedge pclk) disable iff (!presetn)
        timer_two_match |=> state.req1[irq_flags_pkg::pos_timer_two])
        else $error("timer two match flag not set");
    a_timer_one_sets: assert property (@(posedge pclk) disable iff (!presetn)
        timer_one_overflow |=> state.req1[irq_flags_pkg::pos_timer_one_ovf])
        else $error("timer one overflow flag not set");

    // request 2 set terms
    a_comp_two_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[6] |=> state.req2[6])
        else $error("comparator two flag not set");
    a_comp_one_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[5] |=> state.req2[5])
        else $error("comparator one flag not set");
    a_nvm_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[4] |=> state.req2[4])
        else $error("nonvolatile done flag not set");
    a_port_two_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[3] |=> state.req2[3])
        else $error("sync port two flag not set");
    a_port_two_coll: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[2] |=> state.req2[2])
        else $error("sync port two collision flag not set");
    a_timer_four_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[1] |=> state.req2[1])
        else $error("timer four match flag not set");
    a_rollover_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_2_events[0] |=> state.req2[0])
        else $error("oscillator rollover flag not set");
    a_req2_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
        (!state.req2[7] && !request_2_events[7]) |=> !state.req2[7])
        else $error("timer six flag set without an event");

    // bus answers
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response outside the access cycle");
    a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> prdata == irq_flags_pkg::read_zero)
        else $error("unmapped access returned nonzero data");
endmodule : peripheral_irq_flags
`default_nettype wire

// ### pin_change_detect.sv
// per-pin edge detector with rising and falling masks and sticky change flags
`timescale 1ns/100ps
`default_nettype none
module pin_change_detect #(
    parameter int pins = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pins-1:0] pin_in,
    input wire logic [pins-1:0] rising_edge_mask,
    input wire logic [pins-1:0] falling_edge_mask,
    input wire logic [pins-1:0] clear_bits,
    output logic [pins-1:0] per_pin_change_flags
);
    if (pins < 1 || pins > 32) begin : g_bad_pins
        $error("pin_change_detect: pins must be 1..32");
    end

    typedef struct packed {
        logic [pins-1:0] sync_a;
        logic [pins-1:0] sync_b;
        logic [pins-1:0] last;
        logic [pins-1:0] flags;
    } detect_state_t;

    detect_state_t state;
    detect_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.sync_a = pin_in;
        next_state.sync_b = state.sync_a;
        next_state.last = state.sync_b;
        // only enabled edges set a flag; set wins over clear
        next_state.flags = (state.flags & ~clear_bits)
            | (rising_edge_mask & state.sync_b & ~state.last)
            | (falling_edge_mask & ~state.sync_b & state.last);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign per_pin_change_flags = state.flags;

    a_rising_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (rising_edge_mask[0] && state.sync_b[0] && !state.last[0]) |=> state.flags[0])
        else $error("enabled rising edge did not set its flag");
    a_no_edge_no_set: assert property (@(posedge pclk) disable iff (!presetn)
        (!state.flags[0] && !rising_edge_mask[0] && !falling_edge_mask[0]) |=> !state.flags[0])
        else $error("flag set without an enabled edge");
endmodule : pin_change_detect
`default_nettype wire

// ### tb_peripheral_irq_flags.sv
// self-checking bench for the peripheral request flag registers
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_irq_flags;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_in = 8'h00;
    logic rx_buffer_not_empty = 1'b0;
    logic tx_buffer_empty = 1'b0;
    logic [15:0] fire = 16'h0000;
    logic [15:0] events;
    logic [7:0] req0;
    logic [7:0] req1;
    logic [7:0] req2;
    logic [31:0] rdat;
    logic rerr;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2 pclk = ~pclk;

    event_sources u_event_sources (.pclk(pclk), .presetn(presetn), .fire(fire), .events(events));

    peripheral_irq_flags #(.pins(8)) u_peripheral_irq_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .ext_pin_in(events[15]), .timer_zero_overflow(events[0]),
        .timer_one_gate_close(events[1]), .conversion_done(events[2]),
        .rx_buffer_not_empty(rx_buffer_not_empty), .tx_buffer_empty(tx_buffer_empty),
        .port_one_done(events[3]), .port_one_collision(events[4]), .timer_two_match(events[5]),
        .timer_one_overflow(events[6]), .request_2_events(events[14:7]),
        .irq_request_0(req0), .irq_request_1(req1), .irq_request_2(req2));

    ////////////////////////////////////////
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    // events in r are fired so that they meet the access cycle of this transfer
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [15:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        fire <= r;
        @(posedge pclk);
        penable <= 1'b1;
        fire <= 16'h0000;
        // only the bench cycle ceiling ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 16'h0000);
        chk(rdat, exp);
    endtask : rd

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [15:0] r);
        apb(1'b1, a, d, r);
    endtask : wr

    task pulse(input logic [15:0] r);
        fire <= r;
        @(posedge pclk);
        fire <= 16'h0000;
        idle(6);
    endtask : pulse

    ////////////////////////////////////////
    task t_regs;
        rd(irq_flags_pkg::off_request_0, 32'h0000_0000);
        rd(irq_flags_pkg::off_request_2, 32'h0000_0000);
        wr(12'h018, 32'hffff_ffff, 16'h0000);
        rd(12'h018, 32'h0000_0000);
        chk({31'd0, rerr}, 32'h0000_0001);
    endtask : t_regs

    task t_req0;
        pulse(16'h8001);
        chk({24'd0, req0}, 32'h0000_0021);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0021);
        wr(irq_flags_pkg::off_request_0, 32'h0000_00ff, 16'h0000);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0021);
        wr(irq_flags_pkg::off_request_0, 32'h0000_0020, 16'h0000);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0020);
        wr(irq_flags_pkg::off_request_0, 32'h0000_0000, 16'h0000);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0000);
    endtask : t_req0

    task t_req1;
        pulse(16'h007e);
        chk({24'd0, req1}, 32'h0000_00cf);
        rd(irq_flags_pkg::off_request_1, 32'h0000_00cf);
        rx_buffer_not_empty <= 1'b1;
        tx_buffer_empty <= 1'b1;
        idle(3);
        rd(irq_flags_pkg::off_request_1, 32'h0000_00ff);
        wr(irq_flags_pkg::off_request_1, 32'h0000_0000, 16'h0000);
        rd(irq_flags_pkg::off_request_1, 32'h0000_0030);
        rx_buffer_not_empty <= 1'b0;
        idle(3);
        rd(irq_flags_pkg::off_request_1, 32'h0000_0010);
        tx_buffer_empty <= 1'b0;
        idle(3);
        rd(irq_flags_pkg::off_request_1, 32'h0000_0000);
    endtask : t_req1

    task t_req2;
        for (int i = 0; i < 8; i++) begin
            pulse(16'h0080 << i);
            chk({24'd0, req2}, 32'h0000_0001 << i);
            rd(irq_flags_pkg::off_request_2, 32'h0000_0001 << i);
            wr(irq_flags_pkg::off_request_2, 32'h0000_0000, 16'h0000);
            rd(irq_flags_pkg::off_request_2, 32'h0000_0000);
        end
    endtask : t_req2

    task t_pin;
        wr(irq_flags_pkg::off_change_flags, 32'h0000_00ff, 16'h0000);
        pin_in <= 8'h01;
        idle(6);
        rd(irq_flags_pkg::off_change_flags, 32'h0000_0000);
        pin_in <= 8'h00;
        wr(irq_flags_pkg::off_rising_mask, 32'h0000_0001, 16'h0000);
        wr(irq_flags_pkg::off_falling_mask, 32'h0000_0002, 16'h0000);
        pin_in <= 8'h02;
        idle(6);
        rd(irq_flags_pkg::off_change_flags, 32'h0000_0000);
        pin_in <= 8'h01;
        idle(6);
        rd(irq_flags_pkg::off_change_flags, 32'h0000_0003);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0010);
        wr(irq_flags_pkg::off_request_0, 32'h0000_0000, 16'h0000);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0010);
        wr(irq_flags_pkg::off_change_flags, 32'h0000_0001, 16'h0000);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0010);
        wr(irq_flags_pkg::off_change_flags, 32'h0000_0002, 16'h0000);
        idle(2);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0000);
    endtask : t_pin

    task t_race;
        pulse(16'h0001);
        wr(irq_flags_pkg::off_request_0, 32'h0000_0000, 16'h0001);
        rd(irq_flags_pkg::off_request_0, 32'h0000_0020);
        wr(irq_flags_pkg::off_request_2, 32'h0000_0000, 16'h0080);
        rd(irq_flags_pkg::off_request_2, 32'h0000_0001);
    endtask : t_race

    ////////////////////////////////////////
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_req0();
        t_req1();
        t_req2();
        t_pin();
        t_race();
        wrap_up();
    end
endmodule : tb_peripheral_irq_flags
`default_nettype wire
